// ### otg_power_pkg.sv
// constants, register map and carrier types for the otg power and ulpi pin control block
// assumes a 100 MHz mclk and a 32-bit apb register bus
package otg_power_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_MIN_US = 40;
  localparam int POR_CYC = (POR_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_W = $clog2(POR_CYC + 1);
  localparam int POWER_DOWN_DELAY_NS = 500;
  localparam int IDENT_REPORT_TIME_NS = 1000;
  // sync stages plus rx cmd turnaround eat into the report budget
  localparam int IDENT_PIPE_CYC = 4;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_OTG_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_INTERFACE_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam int OTG_CTRL_W = 5;
  localparam logic [OTG_CTRL_W-1:0] OTG_CTRL_RST = 5'h00;
  localparam int IFACE_CTRL_W = 3;
  localparam logic [IFACE_CTRL_W-1:0] IFACE_CTRL_RST = 3'h0;

  localparam int ST_IDENT_GROUNDED = 0;
  localparam int ST_SESSION_END = 1;
  localparam int ST_BUS_POWER_VALID = 2;
  localparam int ST_POR_DONE = 3;
  localparam int ST_IDENT_CHANGE = 4;
  localparam int ST_BUS_POWER_FAULT = 5;
  localparam int ST_EXT_FAULT = 6;
  localparam int ST_POWERED_DOWN = 7;
  localparam int ST_LINK_TX_SEEN = 8;

  // ****************************************
  // rx cmd and low-power byte layout
  // ****************************************
  localparam int RXCMD_VBUS_VALID_BIT = 2;
  localparam int RXCMD_SESSION_END_BIT = 3;
  localparam int RXCMD_IDENT_BIT = 6;
  localparam int LP_INT_BIT = 3;

  typedef enum logic [1:0]
  {
    MODE_SYNC = 2'b00,
    MODE_LOW_POWER = 2'b01,
    MODE_SERIAL3 = 2'b10,
    MODE_SERIAL6 = 2'b11
  } bus_mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_TURN = 2'b01,
    ST_CMD = 2'b10
  } ulpi_state_t;

  typedef struct packed {
    logic extSupplyDriveEn;
    logic hostPowerDriveEn;
    logic busPowerChargeEn;
    logic busPowerDrainEn;
    logic cableIdentPullupEn;
  } otg_ctrl_t;

  typedef struct packed {
    bus_mode_t mode;
    logic switchInvert;
  } iface_ctrl_t;

  // ulpi pad outputs; every enable is low while the pad drives
  typedef struct packed {
    logic [7:0] data;
    logic dataOe_n;
    logic dir;
    logic dirOe_n;
    logic nxt;
    logic nxtOe_n;
    logic clkOe_n;
  } ulpi_pad_t;

  // pins arriving from outside the mclk domain
  typedef struct packed {
    logic chipSel_n;
    logic stp;
    logic identPin;
    logic busPowerValid;
    logic sessionEnd;
    logic faultIn;
    logic [7:0] dataIn;
  } pin_in_t;

  localparam int PIN_IN_W = $bits(pin_in_t);

endpackage

// ### pin_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
// assumes its output is the only place the pins are read
`timescale 1ns/1ps
module pin_sync
  import otg_power_pkg::*;
#(
  parameter int WIDTH = PIN_IN_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // pins
  input wire logic [WIDTH-1:0] pinAsync,
  output logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  // ****************************************
  // stage one feeds stage two only
  // ****************************************
  always_comb
  begin
    nxt_state.stage1 = pinAsync;
    nxt_state.stage2 = state_ff.stage1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign pinSync = state_ff.stage2;

endmodule

// ### otg_power_ctrl.sv
// power-down, power-on reset and otg signalling control behind a ulpi pad ring
// assumes an apb master on mclk and asynchronous pins from the pads and cable
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module otg_power_ctrl
  import otg_power_pkg::*;
#(
  parameter int POWER_DOWN_NS = POWER_DOWN_DELAY_NS,
  parameter int IDENT_REPORT_NS = IDENT_REPORT_TIME_NS
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire pin_in_t pinIn,
  output ulpi_pad_t ulpiPad,
  // analog controls
  output logic internal_power_on_reset_n,
  output logic identSensePullupOn,
  output logic identWeakPullupOn,
  output logic busPowerDrainOn,
  output logic busPowerChargeOn,
  output logic supply_switch_out
);

// Overview of operation
// - chip select high tristates the data, dir and nxt pads and stops internal logic
// - clock pad floats after the power-down delay; link ignores it then
// - internal core reset stays active at least 40 us before release
// - with ident pull-up enabled, a changed ident level raises the flag, and an rx cmd in sync mode
// - ident grounded flag reads 1 for a b-type plug, 0 for a-type
// - with ident pull-up disabled, the weak fallback pull-up is connected instead
// - ident changes are reported within the ident report time, else none happened
// - bus-power-valid is ignored during power-up, otherwise low means fault while the host drive bit is set
// - data bus offers sync 8-bit, low-power, 3-pin and 6-pin serial modes; the serial mode codes are only stored and leave the bus idle
// - double data rate is not offered; only single-rate transfers exist
// - host and external drive bits set drive the supply switch active
// - supply switch polarity can be inverted in the interface control register
// - an external power controller fault input is accepted and recorded
// - chip select low wakes the device and restores ulpi pad operation

  localparam int POWER_DOWN_CYC_RAW = POWER_DOWN_NS / CLK_PERIOD_NS;
  localparam int POWER_DOWN_CYC = (POWER_DOWN_CYC_RAW < 1) ? 1 : POWER_DOWN_CYC_RAW;
  localparam int PD_W = $clog2(POWER_DOWN_CYC + 1);
  localparam int ID_FILT_RAW = IDENT_REPORT_NS / CLK_PERIOD_NS - IDENT_PIPE_CYC;
  localparam int ID_FILT_CYC = (ID_FILT_RAW < 1) ? 1 : ID_FILT_RAW;
  localparam int ID_W = $clog2(ID_FILT_CYC + 1);
  localparam int PD_A = POWER_DOWN_CYC;
  localparam int IDR_A = ID_FILT_CYC + IDENT_PIPE_CYC;

  typedef struct packed {
    otg_ctrl_t otg;
    iface_ctrl_t intf;
    logic [31:0] rdata;
    logic identRep;
    logic identChg;
    logic vbusFault;
    logic extFault;
    logic linkTx;
    logic [POR_W-1:0] porCnt;
    logic porActive;
    logic [PD_W-1:0] pdCnt;
    logic clkOff;
    logic [ID_W-1:0] idCnt;
    ulpi_state_t st;
    logic [7:0] dataOut;
    logic switchOut;
  } ctrl_state_t;

  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;
  pin_in_t pinS;
  logic [31:0] statusWord;
  logic wrEn;
  logic rdSetup;
  logic hit;

  // ****************************************
  // pin synchronisers
  // ****************************************
  pin_sync #(
    .WIDTH(PIN_IN_W)
  ) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pinAsync(pinIn),
    .pinSync(pinS)
  );

  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a == ADDR_OTG_CONTROL) || (a == ADDR_INTERFACE_CONTROL) || (a == ADDR_STATUS);
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  assign hit = addrHit(paddr);
  assign wrEn = psel && penable && pwrite && hit;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = state_ff.rdata;

  always_comb
  begin
    statusWord = '0;
    statusWord[ST_IDENT_GROUNDED] = state_ff.identRep;
    statusWord[ST_SESSION_END] = pinS.sessionEnd;
    statusWord[ST_BUS_POWER_VALID] = pinS.busPowerValid;
    statusWord[ST_POR_DONE] = !state_ff.porActive;
    statusWord[ST_IDENT_CHANGE] = state_ff.identChg;
    statusWord[ST_BUS_POWER_FAULT] = state_ff.vbusFault;
    statusWord[ST_EXT_FAULT] = state_ff.extFault;
    statusWord[ST_POWERED_DOWN] = pinS.chipSel_n;
    statusWord[ST_LINK_TX_SEEN] = state_ff.linkTx;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic clrW1;
    logic idSettled;
    nxt_state = state_ff;
    clrW1 = wrEn && (paddr == ADDR_STATUS);
    idSettled = 1'b0;
    // reads are latched in setup so data leave a flip-flop in the access phase
    if (rdSetup)
    begin
      unique case (paddr)
        ADDR_OTG_CONTROL: nxt_state.rdata = {{(32-OTG_CTRL_W){1'b0}}, state_ff.otg};
        ADDR_INTERFACE_CONTROL: nxt_state.rdata = {{(32-IFACE_CTRL_W){1'b0}}, state_ff.intf};
        ADDR_STATUS: nxt_state.rdata = statusWord;
        default: nxt_state.rdata = '0;
      endcase
    end
    if (wrEn && (paddr == ADDR_OTG_CONTROL))
    begin
      nxt_state.otg = otg_ctrl_t'(pwdata[OTG_CTRL_W-1:0]);
    end
    if (wrEn && (paddr == ADDR_INTERFACE_CONTROL))
    begin
      nxt_state.intf.switchInvert = pwdata[0];
      // every code is a single-rate mode, so no double-rate request can land
      nxt_state.intf.mode = bus_mode_t'(pwdata[2:1]);
    end
    // sticky flags: a set in the same cycle beats a write-one clear
    if (clrW1 && pwdata[ST_IDENT_CHANGE])
    begin
      nxt_state.identChg = 1'b0;
    end
    if (clrW1 && pwdata[ST_BUS_POWER_FAULT])
    begin
      nxt_state.vbusFault = 1'b0;
    end
    if (clrW1 && pwdata[ST_EXT_FAULT])
    begin
      nxt_state.extFault = 1'b0;
    end
    if (clrW1 && pwdata[ST_LINK_TX_SEEN])
    begin
      nxt_state.linkTx = 1'b0;
    end
    if (pinS.faultIn)
    begin
      nxt_state.extFault = 1'b1;
    end
    if (pinS.chipSel_n)
    begin
      // powered down: core reset re-armed, pads released, clock floats later
      nxt_state.porActive = 1'b1;
      nxt_state.porCnt = '0;
      nxt_state.st = ST_IDLE;
      nxt_state.idCnt = '0;
      if (state_ff.pdCnt == PD_W'(POWER_DOWN_CYC))
      begin
        nxt_state.clkOff = 1'b1;
      end
      else
      begin
        nxt_state.pdCnt = state_ff.pdCnt + 1'b1;
      end
    end
    else
    begin
      nxt_state.pdCnt = '0;
      nxt_state.clkOff = 1'b0;
      if (state_ff.porActive)
      begin
        if (state_ff.porCnt == POR_W'(POR_CYC - 1))
        begin
          nxt_state.porActive = 1'b0;
        end
        else
        begin
          nxt_state.porCnt = state_ff.porCnt + 1'b1;
        end
      end
      else
      begin
        if (!pinS.busPowerValid && state_ff.otg.hostPowerDriveEn)
        begin
          nxt_state.vbusFault = 1'b1;
        end
        if (!ulpiPad.dir && (pinS.dataIn != 8'h00))
        begin
          nxt_state.linkTx = 1'b1;
        end
        // ident level must hold steady before it is reported
        if (state_ff.otg.cableIdentPullupEn && (pinS.identPin != state_ff.identRep))
        begin
          if (state_ff.idCnt == ID_W'(ID_FILT_CYC - 1))
          begin
            idSettled = 1'b1;
            nxt_state.idCnt = '0;
          end
          else
          begin
            nxt_state.idCnt = state_ff.idCnt + 1'b1;
          end
        end
        else
        begin
          nxt_state.idCnt = '0;
        end
        if (idSettled)
        begin
          nxt_state.identRep = pinS.identPin;
          nxt_state.identChg = 1'b1;
        end
        unique case (state_ff.st)
          ST_IDLE:
          begin
            if (idSettled && (state_ff.intf.mode == MODE_SYNC))
            begin
              nxt_state.st = ST_TURN;
            end
          end
          ST_TURN:
          begin
            nxt_state.st = pinS.stp ? ST_IDLE : ST_CMD;
          end
          ST_CMD:
          begin
            nxt_state.st = ST_IDLE;
          end
          default:
          begin
            nxt_state.st = ST_IDLE;
          end
        endcase
      end
    end
    nxt_state.dataOut = '0;
    if (state_ff.intf.mode == MODE_LOW_POWER)
    begin
      nxt_state.dataOut[LP_INT_BIT] = state_ff.identChg || state_ff.vbusFault || state_ff.extFault;
    end
    else
    begin
      nxt_state.dataOut[RXCMD_IDENT_BIT] = nxt_state.identRep;
      nxt_state.dataOut[RXCMD_VBUS_VALID_BIT] = pinS.busPowerValid;
      nxt_state.dataOut[RXCMD_SESSION_END_BIT] = pinS.sessionEnd;
    end
    // polarity flip sits after the drive gate so both settings idle safely
    nxt_state.switchOut = (state_ff.otg.hostPowerDriveEn && state_ff.otg.extSupplyDriveEn)
      ^ state_ff.intf.switchInvert;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_ff <= '0;
      state_ff.otg <= OTG_CTRL_RST;
      state_ff.intf <= IFACE_CTRL_RST;
      state_ff.porActive <= 1'b1;
      state_ff.identRep <= 1'b1;
      state_ff.switchOut <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // pad and analog outputs
  // ****************************************
  always_comb
  begin
    logic dirHigh;
    dirHigh = state_ff.porActive || (state_ff.st != ST_IDLE) || (state_ff.intf.mode == MODE_LOW_POWER);
    ulpiPad.dir = dirHigh;
    ulpiPad.dirOe_n = pinS.chipSel_n;
    ulpiPad.nxt = 1'b0;
    ulpiPad.nxtOe_n = pinS.chipSel_n;
    ulpiPad.data = state_ff.dataOut;
    // turnaround cycle and reset hold leave the bus undriven
    ulpiPad.dataOe_n = pinS.chipSel_n || !dirHigh || (state_ff.st == ST_TURN) || state_ff.porActive;
    ulpiPad.clkOe_n = state_ff.clkOff;
  end

  assign internal_power_on_reset_n = !state_ff.porActive;
  assign identSensePullupOn = state_ff.otg.cableIdentPullupEn;
  assign identWeakPullupOn = !state_ff.otg.cableIdentPullupEn;
  assign busPowerDrainOn = state_ff.otg.busPowerDrainEn && !pinS.chipSel_n;
  assign busPowerChargeOn = state_ff.otg.busPowerChargeEn && !pinS.chipSel_n;
  assign supply_switch_out = state_ff.switchOut;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_tristate;
    pinS.chipSel_n |-> ulpiPad.dataOe_n && ulpiPad.dirOe_n && ulpiPad.nxtOe_n;
  endproperty
  a_tristate: assert property (p_tristate) else $error("ulpi pads driven while deselected");

  sequence s_held_down;
    $rose(pinS.chipSel_n) ##1 pinS.chipSel_n [*2];
  endsequence
  property p_clk_float;
    s_held_down |-> !ulpiPad.clkOe_n ##[1:PD_A] ulpiPad.clkOe_n;
  endproperty
  a_clk_float: assert property (p_clk_float) else $error("clock pad not floated after delay");

  property p_por_hold;
    $rose(internal_power_on_reset_n) |-> $past(state_ff.porCnt) == POR_W'(POR_CYC - 1);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core reset released early");

  property p_ident_report;
    state_ff.otg.cableIdentPullupEn && !pinS.chipSel_n && !state_ff.porActive
      && (pinS.identPin != state_ff.identRep) && $stable(pinS.identPin)
      |-> ##[1:IDR_A] (state_ff.identRep == pinS.identPin) || !state_ff.otg.cableIdentPullupEn
      || pinS.chipSel_n || $changed(pinS.identPin);
  endproperty
  a_ident_report: assert property (p_ident_report) else $error("ident change not reported in time");

  property p_rxcmd;
    $rose(state_ff.identChg) && (state_ff.intf.mode == MODE_SYNC) && !pinS.stp
      |-> ulpiPad.dir ##1 !ulpiPad.dataOe_n && (ulpiPad.data[RXCMD_IDENT_BIT] == state_ff.identRep);
  endproperty
  a_rxcmd: assert property (p_rxcmd) else $error("rx cmd missing after ident change");

  property p_weak_pullup;
    wrEn && (paddr == ADDR_OTG_CONTROL) && !pwdata[0] |=> identWeakPullupOn && !identSensePullupOn;
  endproperty
  a_weak_pullup: assert property (p_weak_pullup) else $error("fallback pull-up not connected");

  property p_vbus_fault;
    !pinS.busPowerValid && state_ff.otg.hostPowerDriveEn && !state_ff.porActive && !pinS.chipSel_n
      |=> state_ff.vbusFault;
  endproperty
  a_vbus_fault: assert property (p_vbus_fault) else $error("bus power fault not flagged");

  property p_vbus_ignore;
    state_ff.porActive && !state_ff.vbusFault && !(wrEn && (paddr == ADDR_STATUS)) |=> !state_ff.vbusFault;
  endproperty
  a_vbus_ignore: assert property (p_vbus_ignore) else $error("fault raised during power-up");

  property p_switch;
    wrEn && (paddr == ADDR_OTG_CONTROL) ##1 !$changed(state_ff.intf)
      |=> supply_switch_out == ((state_ff.otg.hostPowerDriveEn && state_ff.otg.extSupplyDriveEn)
      ^ state_ff.intf.switchInvert);
  endproperty
  a_switch: assert property (p_switch) else $error("supply switch level wrong");

  property p_ext_fault;
    $rose(pinIn.faultIn) ##1 pinIn.faultIn [*3] |-> state_ff.extFault;
  endproperty
  a_ext_fault: assert property (p_ext_fault) else $error("fault input not recorded");

  property p_wake;
    $fell(pinS.chipSel_n) |-> !ulpiPad.dirOe_n && ulpiPad.dir ##[1:2] !ulpiPad.clkOe_n;
  endproperty
  a_wake: assert property (p_wake) else $error("pads not restored on wake");

  property p_low_power;
    (state_ff.intf.mode == MODE_LOW_POWER) && !pinS.chipSel_n |-> ulpiPad.dir && !ulpiPad.nxt;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low-power mode lost bus ownership");

endmodule

// ### ulpi_link_model.sv
// link controller model on the ulpi side of otg_power_ctrl
// assumes the bench feeds dataWire and stp back into the pin bundle
`timescale 1ns/1ps
module ulpi_link_model
  import otg_power_pkg::*;
#(
  parameter logic [7:0] RESET_CMD = 8'h80
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus
  input wire ulpi_pad_t ulpiPad,
  input wire logic sendCmd,
  output logic stp,
  output logic [7:0] dataWire,
  // observed
  output logic [7:0] rxByte,
  output logic [31:0] rxCount,
  output logic hostRole
);
  logic [7:0] linkData;
  logic [7:0] lastWire;
  logic dirSeen;
  logic linkDrives;
  // the link backs off while the device holds dir high
  assign linkDrives = !(!ulpiPad.dirOe_n && ulpiPad.dir);
  // undriven bus shows a toggling pattern, not a stale byte
  assign dataWire = !ulpiPad.dataOe_n ? ulpiPad.data : (linkDrives ? linkData : ~lastWire);
  always @(posedge mclk)
  begin
    lastWire <= dataWire;
    if (!rst_n)
    begin
      linkData <= 8'h00;
      stp <= 1'b0;
      dirSeen <= 1'b0;
      rxCount <= 32'h0;
      hostRole <= 1'b0;
    end
    else
    begin
      linkData <= (sendCmd && linkDrives) ? RESET_CMD : 8'h00;
      stp <= (linkData != 8'h00);
      if (!ulpiPad.clkOe_n)
      begin
        dirSeen <= ulpiPad.dir && !ulpiPad.dataOe_n;
        if (ulpiPad.dir && !ulpiPad.dataOe_n)
          rxByte <= dataWire;
        if (dirSeen && !ulpiPad.dir)
        begin
          rxCount <= rxCount + 32'h1;
          hostRole <= !rxByte[RXCMD_IDENT_BIT];
        end
      end
    end
  end
endmodule

// ### ulpi_otg_power_control_tb_top.sv
// self-checking bench for otg_power_ctrl with an apb master and a link model
// assumes the package register map and the hand-over timing
`timescale 1ns/1ps
module ulpi_otg_power_control_tb_top
  import otg_power_pkg::*;
;
  localparam int PD_NS = 500;
  localparam int ID_NS = 1000;
  localparam int ID_BOUND = ID_NS / CLK_PERIOD_NS + IDENT_PIPE_CYC;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic err;} row_t;
  row_t rows [6] = '{
    '{ADDR_OTG_CONTROL, 32'hFFFFFFFF, 32'h0000001F, 1'b0},
    '{ADDR_OTG_CONTROL, 32'h00000000, 32'h00000000, 1'b0},
    '{ADDR_INTERFACE_CONTROL, 32'hFFFFFFFF, 32'h00000007, 1'b0},
    '{ADDR_INTERFACE_CONTROL, 32'h00000000, 32'h00000000, 1'b0},
    '{8'h0C, 32'hFFFFFFFF, 32'h00000000, 1'b1},
    '{8'h40, 32'h0000FFFF, 32'h00000000, 1'b1}};
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rxCount, porCnt;
  logic chipSel_n, identPin, busPowerValid, sessionEnd, faultIn, stp, sendCmd, hostRole, err;
  logic [7:0] dataWire, rxByte;
  logic porN, senseOn, weakOn, drainOn, chargeOn, swOut;
  ulpi_pad_t ulpiPad, padAtFall;
  pin_in_t pinIn;
  int n_fail = 0;
  int n_compared = 0;
  int n;
  assign pinIn = {chipSel_n, stp, identPin, busPowerValid, sessionEnd, faultIn, dataWire};
  otg_power_ctrl #(.POWER_DOWN_NS(PD_NS), .IDENT_REPORT_NS(ID_NS)) dut_u (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .ulpiPad(ulpiPad), .internal_power_on_reset_n(porN),
    .identSensePullupOn(senseOn), .identWeakPullupOn(weakOn), .busPowerDrainOn(drainOn),
    .busPowerChargeOn(chargeOn), .supply_switch_out(swOut));
  ulpi_link_model link_u (.mclk(mclk), .rst_n(rst_n), .ulpiPad(ulpiPad), .sendCmd(sendCmd), .stp(stp),
    .dataWire(dataWire), .rxByte(rxByte), .rxCount(rxCount), .hostRole(hostRole));
  // ****
  // tasks
  // ****
  task conclude();
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_fail++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge: the write is visible and the next setup never re-drives psel in this step
    @(posedge mclk);
  endtask
  task stBit(input int idx, input logic exp, input string m);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd[idx], exp, m);
  endtask
  task waitRx(input logic [31:0] base);
    n = 0;
    while (rxCount === base && n < ID_BOUND)
    begin
      @(posedge mclk);
      n++;
    end
    chk(rxCount, base + 32'h1, "ident report late");
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    conclude();
  end
  // pads only move at the rising edge
  always @(negedge mclk)
    padAtFall = ulpiPad;
  always @(posedge mclk)
    if (rst_n && ulpiPad !== padAtFall)
      chk(ulpiPad, padAtFall, "pad moved off edge");
  always @(posedge mclk)
    porCnt <= (!rst_n || chipSel_n) ? 32'h0 : (porN === 1'b0 ? porCnt + 32'h1 : porCnt);
  // ****
  // main sequence
  // ****
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, sendCmd} = '0;
    {chipSel_n, busPowerValid, sessionEnd, faultIn} = '0;
    identPin = 1'b1;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(porN, 1'b0, "core reset");
    chk(swOut, 1'b0, "switch reset");
    chk({senseOn, weakOn}, 2'b01, "weak pull-up");
    stBit(ST_IDENT_GROUNDED, 1'b1, "ident reset");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].w);
      chk(err, rows[i].err, "write error");
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e, "readback");
      chk(err, rows[i].err, "read error");
    end
    apb(1'b1, ADDR_OTG_CONTROL, 32'h08);
    repeat (10) @(posedge mclk);
    stBit(ST_BUS_POWER_FAULT, 1'b0, "fault in power-up");
    n = 0;
    while (porN !== 1'b1 && n < 5000)
    begin
      @(posedge mclk);
      n++;
    end
    chk(porCnt >= POR_CYC && porN === 1'b1, 1'b1, "core reset short");
    stBit(ST_BUS_POWER_FAULT, 1'b1, "bus power fault");
    busPowerValid <= 1'b1;
    // let the synchronised level settle, else the fault sets again over the clear
    repeat (2) @(posedge mclk);
    apb(1'b1, ADDR_STATUS, 32'h20);
    stBit(ST_BUS_POWER_FAULT, 1'b0, "fault clear");
    apb(1'b1, ADDR_OTG_CONTROL, 32'h18);
    repeat (2) @(posedge mclk);
    chk(swOut, 1'b1, "switch on");
    apb(1'b1, ADDR_INTERFACE_CONTROL, 32'h1);
    repeat (2) @(posedge mclk);
    chk(swOut, 1'b0, "switch inverted");
    apb(1'b1, ADDR_INTERFACE_CONTROL, 32'h0);
    apb(1'b1, ADDR_OTG_CONTROL, 32'h08);
    repeat (2) @(posedge mclk);
    chk(swOut, 1'b0, "switch off");
    sendCmd <= 1'b1;
    @(posedge mclk);
    sendCmd <= 1'b0;
    repeat (6) @(posedge mclk);
    stBit(ST_LINK_TX_SEEN, 1'b1, "link command");
    faultIn <= 1'b1;
    repeat (4) @(posedge mclk);
    stBit(ST_EXT_FAULT, 1'b1, "ext fault");
    faultIn <= 1'b0;
    repeat (4) @(posedge mclk);
    apb(1'b1, ADDR_STATUS, 32'h40);
    stBit(ST_EXT_FAULT, 1'b0, "ext fault clear");
    apb(1'b1, ADDR_OTG_CONTROL, 32'h09);
    chk({senseOn, weakOn}, 2'b10, "sense pull-up");
    for (int v = 0; v < 2; v++)
    begin
      identPin <= v[0];
      waitRx(rxCount);
      chk(rxByte[RXCMD_IDENT_BIT], v[0], "rx cmd ident");
      chk(hostRole, !v[0], "link role");
      stBit(ST_IDENT_GROUNDED, v[0], "ident status");
      stBit(ST_IDENT_CHANGE, 1'b1, "ident change");
      apb(1'b1, ADDR_STATUS, 32'h10);
    end
    apb(1'b1, ADDR_OTG_CONTROL, 32'h08);
    rd = rxCount;
    identPin <= 1'b0;
    repeat (ID_BOUND + 20) @(posedge mclk);
    chk(rxCount, rd, "report while disabled");
    identPin <= 1'b1;
    apb(1'b1, ADDR_OTG_CONTROL, 32'h02);
    repeat (2) @(posedge mclk);
    chk(drainOn, 1'b1, "drain");
    sessionEnd <= 1'b1;
    repeat (4) @(posedge mclk);
    stBit(ST_SESSION_END, 1'b1, "session end");
    apb(1'b1, ADDR_OTG_CONTROL, 32'h04);
    repeat (2) @(posedge mclk);
    chk({drainOn, chargeOn}, 2'b01, "charge");
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, ADDR_INTERFACE_CONTROL, m << 1);
      apb(1'b0, ADDR_INTERFACE_CONTROL, 32'h0);
      chk(rd, m << 1, "mode");
      repeat (4) @(posedge mclk);
      if (m == 1)
        chk({ulpiPad.dir, ulpiPad.dirOe_n}, 2'b10, "low-power dir");
    end
    apb(1'b1, ADDR_INTERFACE_CONTROL, 32'h0);
    chipSel_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({ulpiPad.dataOe_n, ulpiPad.dirOe_n, ulpiPad.nxtOe_n}, 3'b111, "pads float");
    chk(ulpiPad.clkOe_n, 1'b0, "clock early");
    n = 4;
    while (ulpiPad.clkOe_n !== 1'b1 && n < PD_NS / CLK_PERIOD_NS + 10)
    begin
      @(posedge mclk);
      n++;
    end
    chk(n >= PD_NS / CLK_PERIOD_NS && ulpiPad.clkOe_n === 1'b1, 1'b1, "clock float");
    chipSel_n <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({ulpiPad.dir, ulpiPad.dirOe_n, porN}, 3'b100, "wake");
    conclude();
  end
endmodule
